// [rtl/owm_ctrl.sv]
// owm_ctrl: oscillator warm-up and operating mode controller top
`timescale 1ns/10ps
// Overview of operation
// R1: loading compare then enabling an oscillator starts it and the warm-up counter
// R2: source code 00 internal, 01 external high, 10 low frequency
// R3: divider code 00..11 divides the source by 1, 2, 4, 8
// R4: upper eight counter bits equal compare: interrupt, stop, clear
// R5: one compare step is 2^(6+divider code) source periods, 1 to 255 steps
// R6: abort halts and clears the counter, then abort self-clears
// R7: abort keeps enables; restart needs clear then set of an enable
// R8: counting starts only on an enable rising from 0 to 1
// R9: single-clock mode takes the system clock only from the gear clock
// R10: high reference picks external or internal; internal frees crystal pins
// R11: software keeps only one high-frequency source enabled before mode moves
// R12: reset enters normal single mode with the internal oscillator as reference
// R13: idle bit in normal single enters idle with peripherals running
// R14: an enabled pending interrupt ends idle back to normal single
// R15: halt bit in normal single stops all but the time base
// R16: falling edge of the time base source ends time base idle
// R17: time base enabled on entry latches time base interrupt on return
// R18: dual mode uses gear clock normally and low clock divided by four slow
// R19: low crystal pins are general purpose only in single-clock mode
// R20: high reference select writes ignored while low speed clock selected
// R21: start in single-clock mode; dual needs the low oscillator enabled
// R22: normal dual runs the core on gear clock, peripherals on either
// R23: low speed select moves between normal dual and slow
// R24: high crystal enable moves between slow with and without high oscillator
// R25: warm-up interrupt latch stays set until acknowledged
module owm_ctrl
  import owm_pkg::*;
#(
  parameter int unsigned STAGES = OWM_CNT_STAGES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic internal_osc_enable_in,
  input wire logic high_xtal_enable_in,
  input wire logic low_xtal_enable_in,
  input wire logic high_ref_select_wr_in,
  input wire logic high_ref_select_in,
  input wire logic low_speed_sysclk_select_in,
  input wire logic idle_set_in,
  input wire logic timing_gen_halt_set_in,
  input wire logic warmup_abort_wr_in,
  input wire logic [1:0] warmup_source_select_in,
  input wire logic [1:0] warmup_divider_select_in,
  input wire logic [7:0] warmup_compare_value_in,
  input wire logic internal_osc_tick_in,
  input wire logic external_high_tick_in,
  input wire logic low_freq_tick_in,
  input wire logic gear_clock_tick_in,
  input wire logic timebase_source_level_in,
  input wire logic timebase_enable_in,
  input wire logic irq_pending_enabled_in,
  input wire logic warmup_irq_ack_in,
  input wire logic timebase_irq_ack_in,
  output logic warmup_done_irq_out,
  output logic timebase_irq_out,
  output logic warmup_busy_out,
  output logic warmup_abort_out,
  output logic high_ref_select_out,
  output logic [2:0] mode_out,
  output logic dual_clock_out,
  output logic cpu_run_out,
  output logic periph_clk_en_out,
  output logic sysclk_tick_out,
  output logic high_xtal_pins_gpio_out,
  output logic low_xtal_pins_gpio_out,
  output logic internal_osc_run_out,
  output logic high_xtal_run_out,
  output logic low_xtal_run_out
);
  owm_mode_type mode_r;
  owm_mode_type mode_nxt;
  logic int_rise;
  logic xhi_rise;
  logic xlo_rise;
  logic tb_fall;
  logic wu_start;
  logic wu_busy;
  logic wu_match;
  logic tb_armed_r;
  logic [1:0] low_div_r;
  logic sysclk_nxt;

  // ****************************************************************
  // enable and time base source edge detection
  // ****************************************************************
  // only a 0 to 1 change counts, so rewriting a set bit does nothing
  owm_edge_det u_int_edge (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .level_in(internal_osc_enable_in),
    .rise_out(int_rise),
    .fall_out()
  );
  owm_edge_det u_xhi_edge (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .level_in(high_xtal_enable_in),
    .rise_out(xhi_rise),
    .fall_out()
  );
  owm_edge_det u_xlo_edge (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .level_in(low_xtal_enable_in),
    .rise_out(xlo_rise),
    .fall_out()
  );
  owm_edge_det u_tb_edge (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .level_in(timebase_source_level_in),
    .rise_out(),
    .fall_out(tb_fall)
  );
  assign wu_start = int_rise | xhi_rise | xlo_rise; // R8 R1

  // ****************************************************************
  // warm-up counter
  // ****************************************************************
  owm_warmup #(
    .STAGES(STAGES)
  ) u_warmup (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(wu_start),
    .abort_in(warmup_abort_wr_in),
    .source_select_in(warmup_source_select_in),
    .divider_select_in(warmup_divider_select_in),
    .compare_in(warmup_compare_value_in),
    .int_tick_in(internal_osc_tick_in),
    .xhi_tick_in(external_high_tick_in),
    .xlo_tick_in(low_freq_tick_in),
    .busy_out(wu_busy),
    .match_out(wu_match)
  );

  // busy mirrors the counter; abort reads back as a one-cycle echo, then 0
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      warmup_busy_out <= 1'b0;
      warmup_abort_out <= 1'b0;
    end else begin
      warmup_busy_out <= wu_busy;
      warmup_abort_out <= warmup_abort_wr_in; // R6
    end
  end

  // sticky done latch; a match in the ack cycle wins
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      warmup_done_irq_out <= 1'b0;
    end else if (wu_match) begin
      warmup_done_irq_out <= 1'b1; // R25 R4
    end else if (warmup_irq_ack_in) begin
      warmup_done_irq_out <= 1'b0;
    end
  end

  // ****************************************************************
  // high reference select
  // ****************************************************************
  // locked while the low-speed clock drives the system, to avoid glitching fm
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      high_ref_select_out <= 1'b0; // R12
    end else if (high_ref_select_wr_in && !low_speed_sysclk_select_in) begin
      high_ref_select_out <= high_ref_select_in; // R20 R10
    end
  end

  // ****************************************************************
  // operating mode state machine
  // ****************************************************************
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      OWM_NORMAL_SINGLE: begin
        if (timing_gen_halt_set_in) begin
          mode_nxt = OWM_IDLE_TIMEBASE_ONLY; // R15
        end else if (idle_set_in) begin
          mode_nxt = OWM_IDLE_RUN_PERIPHERALS; // R13
        end else if (low_xtal_enable_in) begin
          mode_nxt = OWM_NORMAL_DUAL; // R21
        end
      end
      OWM_IDLE_RUN_PERIPHERALS: begin
        if (irq_pending_enabled_in) begin
          mode_nxt = OWM_NORMAL_SINGLE; // R14
        end
      end
      OWM_IDLE_TIMEBASE_ONLY: begin
        if (tb_fall) begin
          mode_nxt = OWM_NORMAL_SINGLE; // R16
        end
      end
      OWM_NORMAL_DUAL: begin
        if (idle_set_in) begin
          mode_nxt = OWM_IDLE_DUAL;
        end else if (low_speed_sysclk_select_in) begin
          mode_nxt = OWM_SLOW; // R23
        end else if (!low_xtal_enable_in) begin
          mode_nxt = OWM_NORMAL_SINGLE;
        end
      end
      OWM_IDLE_DUAL: begin
        if (irq_pending_enabled_in) begin
          mode_nxt = OWM_NORMAL_DUAL;
        end
      end
      OWM_SLOW: begin
        if (idle_set_in) begin
          mode_nxt = OWM_SLEEP;
        end else if (!low_speed_sysclk_select_in) begin
          mode_nxt = OWM_NORMAL_DUAL; // R23
        end
      end
      OWM_SLEEP: begin
        if (irq_pending_enabled_in) begin
          mode_nxt = OWM_SLOW;
        end
      end
      default: mode_nxt = OWM_NORMAL_SINGLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_r <= OWM_NORMAL_SINGLE; // R12 R21
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // time base enable is sampled on entry to time base idle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tb_armed_r <= 1'b0;
    end else if (mode_r == OWM_NORMAL_SINGLE && mode_nxt == OWM_IDLE_TIMEBASE_ONLY) begin
      tb_armed_r <= timebase_enable_in; // R17
    end
  end

  // latch set on return beats a concurrent ack
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      timebase_irq_out <= 1'b0;
    end else if (mode_r == OWM_IDLE_TIMEBASE_ONLY && tb_fall && tb_armed_r) begin
      timebase_irq_out <= 1'b1; // R17
    end else if (timebase_irq_ack_in) begin
      timebase_irq_out <= 1'b0;
    end
  end

  // ****************************************************************
  // system clock source
  // ****************************************************************
  // slow modes tick once every four low clock ticks
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      low_div_r <= 2'h0;
    end else if (low_freq_tick_in) begin
      low_div_r <= low_div_r + 2'h1;
    end
  end

  always_comb begin
    if (mode_r == OWM_SLOW || mode_r == OWM_SLEEP) begin
      sysclk_nxt = low_freq_tick_in && (low_div_r == OWM_LOW_DIV_MAX); // R18
    end else begin
      sysclk_nxt = gear_clock_tick_in; // R9 R22
    end
  end

  // ****************************************************************
  // mode-derived outputs
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_out <= 3'h0;
      dual_clock_out <= 1'b0;
      cpu_run_out <= 1'b1;
      periph_clk_en_out <= 1'b1;
      sysclk_tick_out <= 1'b0;
      high_xtal_pins_gpio_out <= 1'b1;
      low_xtal_pins_gpio_out <= 1'b1;
      internal_osc_run_out <= 1'b1;
      high_xtal_run_out <= 1'b0;
      low_xtal_run_out <= 1'b0;
    end else begin
      mode_out <= mode_nxt;
      dual_clock_out <= (mode_nxt != OWM_NORMAL_SINGLE) &&
                        (mode_nxt != OWM_IDLE_RUN_PERIPHERALS) &&
                        (mode_nxt != OWM_IDLE_TIMEBASE_ONLY);
      cpu_run_out <= (mode_nxt == OWM_NORMAL_SINGLE) || (mode_nxt == OWM_NORMAL_DUAL) ||
                     (mode_nxt == OWM_SLOW); // R13
      periph_clk_en_out <= (mode_nxt != OWM_IDLE_TIMEBASE_ONLY); // R15 R16
      sysclk_tick_out <= sysclk_nxt;
      high_xtal_pins_gpio_out <= !high_ref_select_out; // R10
      low_xtal_pins_gpio_out <= (mode_nxt == OWM_NORMAL_SINGLE) ||
                                (mode_nxt == OWM_IDLE_RUN_PERIPHERALS) ||
                                (mode_nxt == OWM_IDLE_TIMEBASE_ONLY); // R19
      // abort leaves the enables alone; oscillators follow software only
      internal_osc_run_out <= internal_osc_enable_in; // R7
      high_xtal_run_out <= high_xtal_enable_in; // R24
      low_xtal_run_out <= low_xtal_enable_in;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_enable_rise;
    $rose(high_xtal_enable_in) && !wu_busy && !warmup_abort_wr_in;
  endsequence
  property p_start_on_rise;
    @(posedge ref_clk_in) disable iff (rst_in)
      s_enable_rise |=> wu_busy;
  endproperty
  a_start_on_rise: assert property (p_start_on_rise) else $error("warm-up did not start"); // R1

  property p_no_start_held;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!wu_busy && !wu_start) |=> !wu_busy;
  endproperty
  a_no_start_held: assert property (p_no_start_held) else $error("warm-up started without edge"); // R8

  property p_match_irq;
    @(posedge ref_clk_in) disable iff (rst_in)
      wu_match |=> warmup_done_irq_out && !wu_busy;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match did not raise done"); // R4

  property p_abort_stop;
    @(posedge ref_clk_in) disable iff (rst_in)
      warmup_abort_wr_in |=> !wu_busy ##1 !warmup_abort_out;
  endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("abort did not halt counter"); // R6

  property p_irq_sticky;
    @(posedge ref_clk_in) disable iff (rst_in)
      (warmup_done_irq_out && !warmup_irq_ack_in) |=> warmup_done_irq_out;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("done latch lost"); // R25

  property p_ref_locked;
    @(posedge ref_clk_in) disable iff (rst_in)
      low_speed_sysclk_select_in |=> $stable(high_ref_select_out);
  endproperty
  a_ref_locked: assert property (p_ref_locked) else $error("reference changed while slow"); // R20

  property p_idle_enter;
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode_r == OWM_NORMAL_SINGLE && idle_set_in && !timing_gen_halt_set_in)
        |=> mode_r == OWM_IDLE_RUN_PERIPHERALS ##0 !cpu_run_out;
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle not entered"); // R13

  property p_idle_exit;
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode_r == OWM_IDLE_RUN_PERIPHERALS && irq_pending_enabled_in)
        |=> mode_r == OWM_NORMAL_SINGLE;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not released"); // R14

  property p_tb_exit;
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode_r == OWM_IDLE_TIMEBASE_ONLY && tb_fall)
        |=> mode_r == OWM_NORMAL_SINGLE && periph_clk_en_out;
  endproperty
  a_tb_exit: assert property (p_tb_exit) else $error("time base idle not released"); // R16

  property p_single_pins;
    @(posedge ref_clk_in) disable iff (rst_in)
      (mode_r == OWM_NORMAL_SINGLE) |-> ##1 (mode_r != OWM_NORMAL_SINGLE || low_xtal_pins_gpio_out);
  endproperty
  a_single_pins: assert property (p_single_pins) else $error("low pins not gpio in single"); // R19
endmodule // owm_ctrl

// [rtl/owm_edge_det.sv]
// owm_edge_det: rising and falling edge detector on a synchronous level
`timescale 1ns/10ps
module owm_edge_det (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic level_in,
  output logic rise_out,
  output logic fall_out
);
  logic level_r;
  // ****************************************************************
  // previous level
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      level_r <= level_in; // track the pin in reset so a level already high is no edge
    end else begin
      level_r <= level_in;
    end
  end
  assign rise_out = level_in & ~level_r;
  assign fall_out = ~level_in & level_r;
endmodule // owm_edge_det

// [rtl/owm_pkg.sv]
// owm_pkg: constants and types shared by the warm-up and mode controller
package owm_pkg;
  // ****************************************************************
  // warm-up counter layout
  // ****************************************************************
  localparam int unsigned OWM_CNT_STAGES = 14;
  localparam int unsigned OWM_CMP_WIDTH = 8;
  localparam int unsigned OWM_PRE_WIDTH = 3;
  localparam logic [7:0] OWM_CMP_RESET = 8'h66;
  localparam logic [1:0] OWM_SRC_RESET = 2'h0;
  localparam logic [1:0] OWM_DIV_RESET = 2'h3;
  // ****************************************************************
  // source and mode encodings
  // ****************************************************************
  localparam logic [1:0] OWM_SRC_INT = 2'h0;
  localparam logic [1:0] OWM_SRC_XHI = 2'h1;
  localparam logic [1:0] OWM_SRC_XLO = 2'h2;
  localparam int unsigned OWM_LOW_DIV = 4;
  localparam logic [1:0] OWM_LOW_DIV_MAX = 2'h3;
  typedef enum logic [2:0] {
    OWM_NORMAL_SINGLE,
    OWM_IDLE_RUN_PERIPHERALS,
    OWM_IDLE_TIMEBASE_ONLY,
    OWM_NORMAL_DUAL,
    OWM_IDLE_DUAL,
    OWM_SLOW,
    OWM_SLEEP
  } owm_mode_type;
endpackage

// [rtl/owm_warmup.sv]
// owm_warmup: source select, divider and 14-stage warm-up counter
`timescale 1ns/10ps
module owm_warmup
  import owm_pkg::*;
#(
  parameter int unsigned STAGES = OWM_CNT_STAGES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [1:0] source_select_in,
  input wire logic [1:0] divider_select_in,
  input wire logic [7:0] compare_in,
  input wire logic int_tick_in,
  input wire logic xhi_tick_in,
  input wire logic xlo_tick_in,
  output logic busy_out,
  output logic match_out
);
  logic [OWM_PRE_WIDTH-1:0] pre_r;
  logic [STAGES-1:0] cnt_r;
  logic src_tick;
  logic cnt_tick;
  // ****************************************************************
  // source mux and divider
  // ****************************************************************
  always_comb begin
    src_tick = 1'b0;
    if (source_select_in == OWM_SRC_INT) begin
      src_tick = int_tick_in; // R2
    end else if (source_select_in == OWM_SRC_XHI) begin
      src_tick = xhi_tick_in;
    end else if (source_select_in == OWM_SRC_XLO) begin
      src_tick = xlo_tick_in;
    end
  end
  // divide by 2^code: tick when the low code bits of the prescaler are all ones
  always_comb begin
    cnt_tick = 1'b0;
    case (divider_select_in)
      2'h0: cnt_tick = src_tick;
      2'h1: cnt_tick = src_tick & pre_r[0];
      2'h2: cnt_tick = src_tick & (&pre_r[1:0]);
      default: cnt_tick = src_tick & (&pre_r[2:0]);
    endcase
  end
  assign match_out = busy_out && (cnt_r[STAGES-1 -: OWM_CMP_WIDTH] == compare_in); // R4
  // ****************************************************************
  // counter control; abort and match both clear it and win over start
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      cnt_r <= '0;
      pre_r <= '0;
    end else if (abort_in || match_out) begin
      busy_out <= 1'b0; // R6 R4
      cnt_r <= '0;
      pre_r <= '0;
    end else if (start_in && !busy_out) begin
      busy_out <= 1'b1; // R1
      cnt_r <= '0;
      pre_r <= '0;
    end else if (busy_out) begin
      if (src_tick) begin
        pre_r <= pre_r + 1'b1; // R3
      end
      if (cnt_tick) begin
        cnt_r <= cnt_r + 1'b1; // R5
      end
    end
  end
endmodule // owm_warmup

// [test/tb_top.sv]
// tb_top: self-checking bench for the warm-up counter and operating mode controller
`timescale 1ns/10ps
module tb_top;
  import owm_pkg::*;
  // ****************************************************************
  // stimulus and observation signals
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic osc_en = 1'b1, hx_en = 1'b0, lx_en = 1'b0, ref_dat = 1'b0, low_sel = 1'b0;
  logic tb_lvl = 1'b0, tb_en = 1'b0, pend = 1'b0;
  logic t_int = 1'b0, t_xhi = 1'b0, t_xlo = 1'b0, t_gear = 1'b0;
  logic [5:0] pulse_r = 6'h00;
  logic [3:0] tick_en = 4'h0;
  logic [1:0] src = 2'h0, div = 2'h0;
  logic [7:0] cmp = 8'h01;
  logic done_irq, tb_irq, busy, abort_o, ref_sel_o, dual, cpu_run, periph_en, sys_tick;
  logic hx_gpio, lx_gpio, osc_run, hx_run, lx_run, flag_r;
  logic [2:0] mode;
  logic [3:0] sel_q[$];
  logic [7:0] exp_q[$];
  int errors = 0, comparisons = 0, sys_cnt = 0, gear_cnt = 0, lo_cnt = 0, n;

  always #2 clk = ~clk;

  owm_ctrl dut (
    .ref_clk_in(clk), .rst_in(rst), .internal_osc_enable_in(osc_en),
    .high_xtal_enable_in(hx_en), .low_xtal_enable_in(lx_en),
    .high_ref_select_wr_in(pulse_r[0]), .high_ref_select_in(ref_dat),
    .low_speed_sysclk_select_in(low_sel), .idle_set_in(pulse_r[1]),
    .timing_gen_halt_set_in(pulse_r[2]), .warmup_abort_wr_in(pulse_r[3]),
    .warmup_source_select_in(src), .warmup_divider_select_in(div),
    .warmup_compare_value_in(cmp), .internal_osc_tick_in(t_int),
    .external_high_tick_in(t_xhi), .low_freq_tick_in(t_xlo), .gear_clock_tick_in(t_gear),
    .timebase_source_level_in(tb_lvl), .timebase_enable_in(tb_en),
    .irq_pending_enabled_in(pend), .warmup_irq_ack_in(pulse_r[4]),
    .timebase_irq_ack_in(pulse_r[5]), .warmup_done_irq_out(done_irq),
    .timebase_irq_out(tb_irq), .warmup_busy_out(busy), .warmup_abort_out(abort_o),
    .high_ref_select_out(ref_sel_o), .mode_out(mode), .dual_clock_out(dual),
    .cpu_run_out(cpu_run), .periph_clk_en_out(periph_en), .sysclk_tick_out(sys_tick),
    .high_xtal_pins_gpio_out(hx_gpio), .low_xtal_pins_gpio_out(lx_gpio),
    .internal_osc_run_out(osc_run), .high_xtal_run_out(hx_run), .low_xtal_run_out(lx_run)
  );

  // source ticks one per cycle when enabled; the gear tick is random to expose miscounts
  always @(posedge clk) begin
    t_int <= tick_en[0];
    t_xhi <= tick_en[1];
    t_xlo <= tick_en[2];
    t_gear <= tick_en[3] & 1'($urandom);
    if (t_gear) gear_cnt++;
    if (t_xlo) lo_cnt++;
    if (sys_tick === 1'b1) sys_cnt++;
  end

  // ****************************************************************
  // comparison machinery
  // ****************************************************************
  function automatic logic [7:0] obs(input logic [3:0] sel);
    case (sel)
      4'h0: obs = {5'h00, mode};
      4'h1: obs = {7'h00, done_irq};
      4'h2: obs = {7'h00, tb_irq};
      4'h3: obs = {7'h00, busy};
      4'h4: obs = {7'h00, abort_o};
      4'h5: obs = {7'h00, ref_sel_o};
      4'h6: obs = {7'h00, dual};
      4'h7: obs = {7'h00, cpu_run};
      4'h8: obs = {7'h00, periph_en};
      4'h9: obs = {7'h00, hx_gpio};
      4'ha: obs = {7'h00, lx_gpio};
      4'hb: obs = {7'h00, osc_run};
      4'hc: obs = {7'h00, hx_run};
      4'hd: obs = {7'h00, lx_run};
      default: obs = {7'h00, flag_r};
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [3:0] sel, input logic [7:0] exp);
    sel_q.push_back(sel);
    exp_q.push_back(exp);
  endtask

  // the watcher settles every queued note at the following falling edge
  always @(negedge clk) begin
    while (sel_q.size() > 0) begin
      check(obs(sel_q.pop_front()), exp_q.pop_front());
    end
  end

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // one-cycle strobe on a request line, released on the following edge
  task automatic strobe(input int idx);
    @(posedge clk);
    pulse_r[idx] <= 1'b1;
    @(posedge clk);
    pulse_r <= 6'h00;
  endtask

  task automatic wait_for(input logic [3:0] sel, input logic [7:0] val, input int lim,
                          output int cnt);
    cnt = 0;
    while (obs(sel) !== val) begin
      @(negedge clk);
      cnt++;
      if (cnt > lim) begin
        errors++;
        $display("mismatch at %0t: wait seen %h expected %h", $time, obs(sel), val);
        close_out();
      end
    end
  endtask

  // one software warm-up on the high crystal enable with the given settings
  task automatic warm(input logic [1:0] s, input logic [1:0] d, input logic [7:0] c);
    int t;
    t = int'(c) << (6 + int'(d));
    @(posedge clk);
    src <= s;
    div <= d;
    cmp <= c;
    tick_en <= 4'h1 << s;
    hx_en <= 1'b0;
    cyc(3);
    hx_en <= 1'b1;
    wait_for(4'h1, 8'h01, t + 64, n);
    flag_r = (n >= t - 2) && (n <= t + (1 << d) + 6);
    note(4'hf, 8'h01);
    cyc(3);
    note(4'h3, 8'h00);
    note(4'h1, 8'h01);
    cyc(6);
    note(4'h3, 8'h00);
    strobe(4);
    cyc(2);
    note(4'h1, 8'h00);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'ha321));
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    note(4'h0, 8'h00);
    note(4'h5, 8'h00);
    note(4'h6, 8'h00);
    note(4'ha, 8'h01);
    note(4'h9, 8'h01);
    note(4'hb, 8'h01);
    note(4'h3, 8'h00);
    $display("test reset done");
    for (int s = 0; s < 3; s++) begin
      for (int d = 0; d < 4; d++) begin
        warm(2'(s), 2'(d), 8'(1 + ($urandom % 2)));
      end
    end
    note(4'hc, 8'h01);
    $display("test warmup done");
    // abort in mid-count keeps the enables and needs a clear before restart
    cmp <= 8'hff;
    hx_en <= 1'b0;
    cyc(2);
    hx_en <= 1'b1;
    cyc(20);
    note(4'h3, 8'h01);
    strobe(3);
    note(4'h4, 8'h01);
    cyc(3);
    note(4'h3, 8'h00);
    note(4'h4, 8'h00);
    note(4'hc, 8'h01);
    cyc(10);
    note(4'h3, 8'h00);
    hx_en <= 1'b0;
    cyc(2);
    hx_en <= 1'b1;
    cyc(4);
    note(4'h3, 8'h01);
    strobe(3);
    hx_en <= 1'b0;
    tick_en <= 4'h8;
    $display("test abort done");
    // single-clock system clock follows the gear clock one for one
    cyc(2);
    sys_cnt = 0;
    gear_cnt = 0;
    cyc(64);
    flag_r = (sys_cnt - gear_cnt <= 1) && (gear_cnt - sys_cnt <= 1);
    note(4'hf, 8'h01);
    // idle with peripherals running, ended by an enabled pending interrupt
    strobe(1);
    cyc(2);
    note(4'h0, 8'h01);
    note(4'h7, 8'h00);
    note(4'h8, 8'h01);
    pend <= 1'b1;
    cyc(3);
    note(4'h0, 8'h00);
    note(4'h7, 8'h01);
    pend <= 1'b0;
    $display("test idle done");
    // time base idle with and without the time base enabled on entry
    for (int te = 1; te >= 0; te--) begin
      tb_en <= 1'(te);
      tb_lvl <= 1'b1;
      strobe(2);
      cyc(2);
      note(4'h0, 8'h02);
      note(4'h8, 8'h00);
      note(4'hb, 8'h01);
      cyc(5);
      note(4'h0, 8'h02);
      tb_lvl <= 1'b0;
      cyc(4);
      note(4'h0, 8'h00);
      note(4'h8, 8'h01);
      note(4'h2, 8'(te));
      strobe(5);
      cyc(2);
      note(4'h2, 8'h00);
    end
    $display("test halt done");
    // dual-clock entry, slow mode and reference select lockout
    lx_en <= 1'b1;
    cyc(3);
    note(4'h0, 8'h03);
    note(4'h6, 8'h01);
    note(4'ha, 8'h00);
    note(4'h7, 8'h01);
    note(4'hd, 8'h01);
    strobe(1);
    cyc(2);
    note(4'h0, 8'h04);
    note(4'h7, 8'h00);
    pend <= 1'b1;
    cyc(3);
    note(4'h0, 8'h03);
    pend <= 1'b0;
    low_sel <= 1'b1;
    cyc(3);
    note(4'h0, 8'h05);
    ref_dat <= 1'b1;
    strobe(0);
    cyc(2);
    note(4'h5, 8'h00);
    strobe(1);
    cyc(2);
    note(4'h0, 8'h06);
    pend <= 1'b1;
    cyc(3);
    note(4'h0, 8'h05);
    pend <= 1'b0;
    tick_en <= 4'hc;
    cyc(2);
    sys_cnt = 0;
    lo_cnt = 0;
    cyc(64);
    flag_r = (sys_cnt * 4 >= lo_cnt - 4) && (sys_cnt * 4 <= lo_cnt + 4);
    note(4'hf, 8'h01);
    hx_en <= 1'b1;
    cyc(3);
    note(4'hc, 8'h01);
    hx_en <= 1'b0;
    cyc(3);
    note(4'hc, 8'h00);
    low_sel <= 1'b0;
    cyc(3);
    note(4'h0, 8'h03);
    strobe(0);
    cyc(2);
    note(4'h5, 8'h01);
    note(4'h9, 8'h00);
    ref_dat <= 1'b0;
    strobe(0);
    lx_en <= 1'b0;
    cyc(3);
    note(4'h9, 8'h01);
    note(4'h0, 8'h00);
    note(4'ha, 8'h01);
    note(4'hd, 8'h00);
    $display("test dual done");
    cyc(2);
    close_out();
  end
endmodule // tb_top
